/* logic/encode_and_file_move.sv */
// bit position encoder and file block copy/fill engine behind an AXI4-Lite slave
// assumes a same-clock data table: read data valid the cycle after table_re
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module encode_and_file_move #(
    parameter int DATA_W = encode_file_pkg::DATA_W,
    parameter int TABLE_AW = encode_file_pkg::TABLE_AW
) (
    input wire logic sys_clk, // 200 MHz
    input wire logic reset_n, // async, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [TABLE_AW-1:0] table_addr, // data table word address
    output logic [DATA_W-1:0] table_wdata, // data table write word
    output logic table_we, // data table write strobe
    output logic table_re, // data table read strobe
    input wire logic [DATA_W-1:0] table_rdata // read word, one cycle after table_re
);
    // encoder and flag logic are written for a 16-bit word only
    if (DATA_W != 16 || TABLE_AW < 8 || TABLE_AW > 16) begin : g_bad_width
        $error("encode_and_file_move: unsupported width");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_READ = 3'b001, ST_CAPTURE = 3'b010, ST_WRITE = 3'b011, ST_FINISH = 3'b100
    } state_t;

    // bus handshake group
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held, next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid;
    logic [31:0] next_rdata;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;

    // core group
    state_t state, next_state;
    encode_file_pkg::op_t op, next_op;
    logic [TABLE_AW-1:0] src_addr, dst_addr, next_src_addr, next_dst_addr;
    logic [7:0] length, next_length;
    logic [3:0] file_type, next_file_type;
    logic [15:0] arith_flags, next_arith_flags;
    logic [15:0] index_reg, next_index_reg;
    logic [15:0] fill_value, next_fill_value;
    logic minor_trap, next_minor_trap;
    logic major_fault, next_major_fault;
    logic busy, done, len_err, next_busy, next_done, next_len_err;
    logic [15:0] count, total, next_count, next_total;
    logic [DATA_W-1:0] hold_word, next_hold_word;
    logic [TABLE_AW-1:0] next_table_addr;
    logic [DATA_W-1:0] next_table_wdata;
    logic next_table_we, next_table_re;

    // combinational views: encoder of the captured word, length limit and word count, write byte mask
    logic [3:0] low_pos;
    logic multi_set;
    logic [7:0] max_len;
    logic [1:0] words_per;
    logic [15:0] words_needed;
    logic [31:0] wmask;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = w_strb[b] ? 8'hFF : 8'h00;
        end
    end

    always_comb begin
        low_pos = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (hold_word[i]) begin
                low_pos = 4'(i);
            end
        end
        multi_set = |(hold_word & (hold_word - 16'h0001));
    end

    always_comb begin
        unique case (file_type[2:0])
            encode_file_pkg::FT_OUTPUT: max_len = file_type[encode_file_pkg::FT_ANALOG_BIT] ?
                encode_file_pkg::MAX_OUT_ANA : encode_file_pkg::MAX_OUT_DISC;
            encode_file_pkg::FT_INPUT: max_len = file_type[encode_file_pkg::FT_ANALOG_BIT] ?
                encode_file_pkg::MAX_IN_ANA : encode_file_pkg::MAX_IN_DISC;
            encode_file_pkg::FT_STATUS: max_len = encode_file_pkg::MAX_STATUS;
            encode_file_pkg::FT_BIT: max_len = encode_file_pkg::MAX_BIT;
            encode_file_pkg::FT_TIMER: max_len = encode_file_pkg::MAX_TIMER;
            encode_file_pkg::FT_COUNTER: max_len = encode_file_pkg::MAX_COUNTER;
            encode_file_pkg::FT_CONTROL: max_len = encode_file_pkg::MAX_CONTROL;
            encode_file_pkg::FT_INTEGER: max_len = encode_file_pkg::MAX_INTEGER;
        endcase
        // timers, counters and controls are three-word elements
        words_per = (file_type[2:0] == encode_file_pkg::FT_TIMER || file_type[2:0] == encode_file_pkg::FT_COUNTER ||
            file_type[2:0] == encode_file_pkg::FT_CONTROL) ? encode_file_pkg::WORDS_STRUCT :
            encode_file_pkg::WORDS_PLAIN;
        words_needed = 16'(length * words_per);
    end

    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            encode_file_pkg::OFS_SRC_ADDR: rd_word = 32'(src_addr);
            encode_file_pkg::OFS_DST_ADDR: rd_word = 32'(dst_addr);
            encode_file_pkg::OFS_LENGTH: rd_word = 32'(length);
            encode_file_pkg::OFS_FILE_TYPE: rd_word = 32'(file_type);
            encode_file_pkg::OFS_ARITH_FLAGS: rd_word = 32'(arith_flags);
            encode_file_pkg::OFS_TRAP: rd_word = 32'({major_fault, minor_trap});
            encode_file_pkg::OFS_INDEX: rd_word = 32'(index_reg);
            encode_file_pkg::OFS_STATUS: rd_word = 32'({len_err, done, busy});
            encode_file_pkg::OFS_FILL_VALUE: rd_word = 32'(fill_value);
            encode_file_pkg::OFS_CTRL: rd_word = 32'({op, 1'b0});
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
        unique case (aw_addr)
            encode_file_pkg::OFS_CTRL, encode_file_pkg::OFS_SRC_ADDR, encode_file_pkg::OFS_DST_ADDR,
            encode_file_pkg::OFS_LENGTH, encode_file_pkg::OFS_FILE_TYPE, encode_file_pkg::OFS_ARITH_FLAGS,
            encode_file_pkg::OFS_TRAP, encode_file_pkg::OFS_INDEX, encode_file_pkg::OFS_STATUS,
            encode_file_pkg::OFS_FILL_VALUE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? encode_file_pkg::RESP_OKAY : encode_file_pkg::RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_axi_rvalid) begin
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = rd_hit ? encode_file_pkg::RESP_OKAY : encode_file_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    always_comb begin
        logic [31:0] wv;
        logic go;
        wv = 32'h0000_0000;
        go = 1'b0;
        next_state = state;
        next_op = op;
        next_src_addr = src_addr;
        next_dst_addr = dst_addr;
        next_length = length;
        next_file_type = file_type;
        next_arith_flags = arith_flags;
        next_index_reg = index_reg;
        next_fill_value = fill_value;
        next_minor_trap = minor_trap;
        next_major_fault = major_fault;
        next_busy = busy;
        next_done = done;
        next_len_err = len_err;
        next_count = count;
        next_total = total;
        next_hold_word = hold_word;
        next_table_addr = table_addr;
        next_table_wdata = table_wdata;
        next_table_we = 1'b0;
        next_table_re = 1'b0;
        if (wr_fire) begin
            unique case (aw_addr)
                encode_file_pkg::OFS_SRC_ADDR: begin
                    wv = (32'(src_addr) & ~wmask) | (w_data & wmask);
                    next_src_addr = wv[TABLE_AW-1:0];
                end
                encode_file_pkg::OFS_DST_ADDR: begin
                    wv = (32'(dst_addr) & ~wmask) | (w_data & wmask);
                    next_dst_addr = wv[TABLE_AW-1:0];
                end
                encode_file_pkg::OFS_LENGTH: if (w_strb[0]) next_length = w_data[7:0];
                encode_file_pkg::OFS_FILE_TYPE: if (w_strb[0]) next_file_type = w_data[3:0];
                encode_file_pkg::OFS_ARITH_FLAGS: begin
                    wv = (32'(arith_flags) & ~wmask) | (w_data & wmask);
                    next_arith_flags = wv[15:0];
                end
                encode_file_pkg::OFS_INDEX: begin
                    wv = (32'(index_reg) & ~wmask) | (w_data & wmask);
                    next_index_reg = wv[15:0];
                end
                encode_file_pkg::OFS_FILL_VALUE: begin
                    wv = (32'(fill_value) & ~wmask) | (w_data & wmask);
                    next_fill_value = wv[15:0];
                end
                encode_file_pkg::OFS_TRAP: if (w_strb[0]) begin
                    next_minor_trap = w_data[encode_file_pkg::TRAP_MINOR_BIT];
                    if (w_data[encode_file_pkg::TRAP_MAJOR_BIT]) next_major_fault = 1'b0;
                end
                encode_file_pkg::OFS_CTRL: if (w_strb[0]) begin
                    // end-of-program check sees the trap as it stood before this write
                    if (w_data[encode_file_pkg::CTRL_EOP_BIT] && minor_trap) next_major_fault = 1'b1;
                    // rung false: no operation starts, but the end-of-program check above still applies
                    go = w_data[encode_file_pkg::CTRL_GO_BIT] && w_data[encode_file_pkg::CTRL_RUNG_BIT] && !busy;
                    if (go) next_op = encode_file_pkg::op_t'(w_data[encode_file_pkg::CTRL_OP_LSB +: 2]);
                end
                default: ;
            endcase
        end
        unique case (state)
            ST_IDLE: if (go) begin
                next_count = 16'h0000;
                next_done = 1'b0;
                next_len_err = 1'b0;
                unique case (next_op)
                    encode_file_pkg::OP_ENCODE: begin
                        next_busy = 1'b1;
                        next_total = 16'h0001;
                        next_table_addr = src_addr;
                        next_table_re = 1'b1;
                        next_state = ST_READ;
                    end
                    encode_file_pkg::OP_COPY, encode_file_pkg::OP_FILL: begin
                        next_total = words_needed;
                        if (length > max_len || length == 8'h00) begin
                            next_len_err = 1'b1;
                            next_done = 1'b1;
                        end else begin
                            next_busy = 1'b1;
                            if (next_op == encode_file_pkg::OP_FILL && w_data[encode_file_pkg::CTRL_CONST_BIT]) begin
                                next_hold_word = fill_value;
                                next_table_addr = dst_addr;
                                next_table_wdata = fill_value;
                                next_table_we = 1'b1;
                                next_state = ST_WRITE;
                            end else begin
                                next_table_addr = src_addr;
                                next_table_re = 1'b1;
                                next_state = ST_READ;
                            end
                        end
                    end
                    default: ;
                endcase
            end
            ST_READ: next_state = ST_CAPTURE;
            ST_CAPTURE: begin
                next_hold_word = table_rdata;
                next_table_addr = TABLE_AW'(dst_addr + count);
                next_table_wdata = table_rdata;
                next_table_we = 1'b1;
                next_state = ST_WRITE;
                if (op == encode_file_pkg::OP_ENCODE) begin
                    // result computed from the just-captured word
                    next_table_wdata = 16'h0000;
                    for (int i = 15; i >= 0; i--) begin
                        if (table_rdata[i]) next_table_wdata = 16'(i);
                    end
                end
            end
            ST_WRITE: begin
                if (op == encode_file_pkg::OP_ENCODE) begin
                    next_arith_flags[encode_file_pkg::FLAG_CARRY] = 1'b0;
                    next_arith_flags[encode_file_pkg::FLAG_OVF] = multi_set;
                    next_arith_flags[encode_file_pkg::FLAG_ZERO] = (low_pos == 4'h0);
                    next_arith_flags[encode_file_pkg::FLAG_SIGN] = 1'b0;
                end
                next_count = count + 16'h0001;
                if (count + 16'h0001 >= total) begin
                    next_state = ST_FINISH;
                end else if (op == encode_file_pkg::OP_COPY) begin
                    next_table_addr = TABLE_AW'(src_addr + count + 16'h0001);
                    next_table_re = 1'b1;
                    next_state = ST_READ;
                end else begin
                    next_table_addr = TABLE_AW'(dst_addr + count + 16'h0001);
                    next_table_wdata = hold_word;
                    next_table_we = 1'b1;
                end
            end
            ST_FINISH: begin
                if (op != encode_file_pkg::OP_ENCODE) next_index_reg = 16'h0000;
                next_busy = 1'b0;
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            op <= encode_file_pkg::OP_NONE;
            src_addr <= '0;
            dst_addr <= '0;
            length <= 8'h00;
            file_type <= 4'h0;
            arith_flags <= encode_file_pkg::ARITH_FLAGS_RESET;
            index_reg <= encode_file_pkg::INDEX_RESET;
            fill_value <= 16'h0000;
            minor_trap <= 1'b0;
            major_fault <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            len_err <= 1'b0;
            count <= 16'h0000;
            total <= 16'h0000;
            hold_word <= 16'h0000;
            table_addr <= '0;
            table_wdata <= '0;
            table_we <= 1'b0;
            table_re <= 1'b0;
        end else begin
            state <= next_state;
            op <= next_op;
            src_addr <= next_src_addr;
            dst_addr <= next_dst_addr;
            length <= next_length;
            file_type <= next_file_type;
            arith_flags <= next_arith_flags;
            index_reg <= next_index_reg;
            fill_value <= next_fill_value;
            minor_trap <= next_minor_trap;
            major_fault <= next_major_fault;
            busy <= next_busy;
            done <= next_done;
            len_err <= next_len_err;
            count <= next_count;
            total <= next_total;
            hold_word <= next_hold_word;
            table_addr <= next_table_addr;
            table_wdata <= next_table_wdata;
            table_we <= next_table_we;
            table_re <= next_table_re;
        end
    end
endmodule : encode_and_file_move
`default_nettype wire

/* logic/encode_file_pkg.sv */
// constants for the encoder and file copy/fill engine
// assumes a 16-bit data table behind a one-cycle read port
package encode_file_pkg;
    localparam int DATA_W = 16;
    localparam int TABLE_AW = 16;
    localparam int LEN_W = 8;
    // register byte addresses on the 32-bit bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SRC_ADDR = 8'h04;
    localparam logic [7:0] OFS_DST_ADDR = 8'h08;
    localparam logic [7:0] OFS_LENGTH = 8'h0C;
    localparam logic [7:0] OFS_FILE_TYPE = 8'h10;
    localparam logic [7:0] OFS_ARITH_FLAGS = 8'h14;
    localparam logic [7:0] OFS_TRAP = 8'h18;
    localparam logic [7:0] OFS_INDEX = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_FILL_VALUE = 8'h24;
    // control word, file type, trap and status field bit positions
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_RUNG_BIT = 3;
    localparam int CTRL_CONST_BIT = 4;
    localparam int CTRL_EOP_BIT = 5;
    localparam int FT_ANALOG_BIT = 3;
    localparam int TRAP_MINOR_BIT = 0;
    localparam int TRAP_MAJOR_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_LEN_ERR_BIT = 2;
    // arithmetic flag positions in the flags word
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_OVF = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_SIGN = 3;
    localparam logic [15:0] ARITH_FLAGS_RESET = 16'h0000;
    localparam logic [15:0] INDEX_RESET = 16'h0000;
    // words per element of a structured or a plain destination
    localparam logic [1:0] WORDS_STRUCT = 2'h3;
    localparam logic [1:0] WORDS_PLAIN = 2'h1;
    // longest length per destination type
    localparam logic [7:0] MAX_OUT_DISC = 8'h01;
    localparam logic [7:0] MAX_OUT_ANA = 8'h05;
    localparam logic [7:0] MAX_IN_DISC = 8'h02;
    localparam logic [7:0] MAX_IN_ANA = 8'h08;
    localparam logic [7:0] MAX_STATUS = 8'h21;
    localparam logic [7:0] MAX_BIT = 8'h20;
    localparam logic [7:0] MAX_TIMER = 8'h28;
    localparam logic [7:0] MAX_COUNTER = 8'h20;
    localparam logic [7:0] MAX_CONTROL = 8'h10;
    localparam logic [7:0] MAX_INTEGER = 8'h69;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {OP_ENCODE = 2'b00, OP_COPY = 2'b01, OP_FILL = 2'b10, OP_NONE = 2'b11} op_t;
    typedef enum logic [2:0] {
        FT_OUTPUT = 3'b000, FT_INPUT = 3'b001, FT_STATUS = 3'b010, FT_BIT = 3'b011,
        FT_TIMER = 3'b100, FT_COUNTER = 3'b101, FT_CONTROL = 3'b110, FT_INTEGER = 3'b111
    } file_type_t;
endpackage : encode_file_pkg

/* tb/efm_sva.sv */
// checker: bus handshakes and data table strobes
// assumes bind onto encode_and_file_move
`timescale 1ns/1ps
`default_nettype none
module efm_sva (
    input wire logic sys_clk, // clock
    input wire logic reset_n, // reset
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic table_we, // write strobe
    input wire logic table_re, // read strobe
    input wire logic [15:0] table_addr // word address
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence wr_follows;
        ##[2:3] table_we;
    endsequence
    rd_then_wr_a: assert property (table_re |-> wr_follows) else $error("read not followed by write");
    re_pulse_a: assert property (table_re |=> !table_re) else $error("read strobe too long");
    fill_step_a: assert property (table_we && $past(table_we) |-> table_addr == $past(table_addr) + 16'h1)
        else $error("fill address not ascending");
    strobes_apart_a: assert property (!(table_re && table_we)) else $error("read and write strobes together");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
endmodule : efm_sva
bind encode_and_file_move efm_sva i_sva (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .table_we(table_we), .table_re(table_re),
    .table_addr(table_addr));
`default_nettype wire

/* tb/testbench.sv */
// bench: encode, copy and fill runs through the register bus
// assumes a one-cycle data table owned by the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, sys_clk = 1'h0, reset_n = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, table_we, table_re;
    logic [15:0] table_addr, table_wdata, table_rdata = 16'h0, v, p, mem [256];
    int fail_count = 0, checks_done = 0, cyc = 0, i;
    encode_and_file_move i_dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .table_addr,
        .table_wdata, .table_we, .table_re, .table_rdata);
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (table_we) mem[table_addr[7:0]] <= table_wdata;
        table_rdata <= mem[table_addr[7:0]];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run;
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // channels judged on pre-edge values at the rising edge, released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic hb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge sys_clk);
            hb = s_axi_bvalid & s_axi_bready;
            if (s_axi_awvalid & s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid & s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!hb);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic h;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge sys_clk);
            h = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (s_axi_arvalid & s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!h);
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
    endtask : rchk
    task automatic run(input logic [31:0] c);
        logic [31:0] s;
        logic [1:0] r;
        wr(encode_file_pkg::OFS_CTRL, c);
        do rd(encode_file_pkg::OFS_STATUS, s, r); while (s[0] | !s[1]);
    endtask : run
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'h1;
        wr(encode_file_pkg::OFS_SRC_ADDR, 32'h10);
        wr(encode_file_pkg::OFS_DST_ADDR, 32'h20);
        for (i = 0; i < 18; i++) begin
            v = (i < 16) ? 16'h1 << i : ((i == 16) ? 16'h0 : 16'h0A00);
            p = (i < 16) ? 16'(i) : ((i == 16) ? 16'h0 : 16'h9);
            mem[16] = v;
            mem[32] = 16'hFFFF;
            wr(encode_file_pkg::OFS_ARITH_FLAGS, 32'hFFFF);
            run(32'h9);
            chk(mem[32], p);
            rchk(encode_file_pkg::OFS_ARITH_FLAGS, {16'h0, 12'hFFF, 1'h0, p == 16'h0, i == 17, 1'h0});
        end
        rchk(encode_file_pkg::OFS_TRAP, 32'h0);
        mem[32] = 16'h1234;
        wr(encode_file_pkg::OFS_ARITH_FLAGS, 32'h5);
        run(32'h1);
        chk(mem[32], 32'h1234);
        // overlapping copy: ascending order propagates the first word
        for (i = 0; i < 5; i++) mem[64 + i] = 16'(i);
        wr(encode_file_pkg::OFS_SRC_ADDR, 32'h40);
        wr(encode_file_pkg::OFS_DST_ADDR, 32'h41);
        wr(encode_file_pkg::OFS_LENGTH, 32'h3);
        wr(encode_file_pkg::OFS_FILE_TYPE, 32'h7);
        wr(encode_file_pkg::OFS_INDEX, 32'h5);
        run(32'hB);
        for (i = 1; i < 5; i++) chk(mem[64 + i], (i < 4) ? 32'h0 : 32'h4);
        rchk(encode_file_pkg::OFS_INDEX, 32'h0);
        rchk(encode_file_pkg::OFS_ARITH_FLAGS, 32'h5);
        mem[102] = 16'h0;
        wr(encode_file_pkg::OFS_DST_ADDR, 32'h60);
        wr(encode_file_pkg::OFS_LENGTH, 32'h2);
        wr(encode_file_pkg::OFS_FILE_TYPE, 32'h5);
        wr(encode_file_pkg::OFS_FILL_VALUE, 32'h5A5A);
        wr(encode_file_pkg::OFS_INDEX, 32'h5);
        run(32'h1D);
        for (i = 0; i < 7; i++) chk(mem[96 + i], (i < 6) ? 32'h5A5A : 32'h0);
        rchk(encode_file_pkg::OFS_INDEX, 32'h0);
        rchk(encode_file_pkg::OFS_ARITH_FLAGS, 32'h5);
        // one control element from zeroed source words: three words land
        wr(encode_file_pkg::OFS_FILE_TYPE, 32'h6);
        wr(encode_file_pkg::OFS_LENGTH, 32'h1);
        run(32'hB);
        for (i = 0; i < 4; i++) chk(mem[96 + i], (i < 3) ? 32'h0 : 32'h5A5A);
        wr(encode_file_pkg::OFS_FILE_TYPE, 32'h7);
        for (i = 105; i < 107; i++) begin
            wr(encode_file_pkg::OFS_LENGTH, 32'(i));
            run(32'hD);
            rchk(encode_file_pkg::OFS_STATUS, (i == 106) ? 32'h6 : 32'h2);
        end
        chk(mem[200], 32'h0);
        rd(8'h30, d, r);
        chk(32'(r), 32'(encode_file_pkg::RESP_SLVERR));
        wr(encode_file_pkg::OFS_TRAP, 32'h1);
        wr(encode_file_pkg::OFS_CTRL, 32'h20);
        rchk(encode_file_pkg::OFS_TRAP, 32'h3);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
